// >>> iobus_processor.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
// How it works
// - Eighteen shared data lines, strobed after settling
// - Channel uses memory buffer, program uses accumulator
// - Clear pulse on power-up, clear instruction, key
// - Clear with select code starts read-in
// - Sync pulse once each processor cycle
// - Input and output pulses generated automatically
// - First pulse: skip test or command only
// - Second pulse: device sends data or clears
// - Third pulse: device captures processor data only
// - Read flags loads 18-bit status word
// - Overflow when word counter increments to zero
// - Overflow on memory increment wrap
// - Data overflow in third add cycle
// - Interrupt traps to 00000, executes 00001
// - Skip level advances counter one extra
// - Read and write requests move one word
// - Increment request adds one at address
// - Inhibit stops current address increment
// - Instruction bits 4-11 drive selection lines
// - Granted device drives vector or count address
// - Four interrupt, two channel request lines
// - Enable chain favours nearest device
module iobus_processor
    import iobus_pkg::*;
#(
    parameter int CYCLE = `IO_CYCLE_CLKS
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Bus
    iobus_if.proc BUS,
    // Console and instruction input
    input wire logic RESET_KEY,
    input wire logic CMD_VALID,
    output logic CMD_READY,
    input wire logic [17:0] CMD_INSTR,
    input wire logic [2:0] CMD_OP,
    input wire logic [17:0] CMD_ACC,
    // Channel memory side
    input wire logic [17:0] MEM_WORD,
    input wire logic [17:0] WORD_COUNT,
    input wire logic [14:0] CUR_ADDR,
    // Results
    output logic [17:0] ACCUMULATOR,
    output logic [14:0] PC_ADVANCE,
    output logic [14:0] TRAP_ADDR,
    output logic TRAP,
    output logic [14:0] NEXT_CUR_ADDR,
    output logic [14:0] INC_ADDR,
    output logic [17:0] IN_VALID_WORD,
    output logic IN_VALID,
    input wire logic IN_READY,
    output logic [14:0] VECTOR
);
    pstate_t st_q;
    logic [6:0] ph_q;
    logic [1:0] sub_q;
    logic pon_q;
    logic [17:0] instr_q;
    logic [17:0] acc_q;
    logic [2:0] op_q;
    logic chan_wr_q;
    logic [14:0] addr_q;
    logic f_valid;
    logic f_ready;
    logic cyc_end;
    logic [18:0] inc_sum;
    logic [1:0] chreq_q;
    logic [3:0] apireq_q;
    logic busy_req;
    assign cyc_end = (ph_q == 7'(CYCLE - 1));
    // Pending bus service outranks a program command
    assign busy_req = (|BUS.chan_req && (BUS.read_req || BUS.write_req)) ||
        BUS.mem_inc_req || (|BUS.api_req);
    assign CMD_READY = (st_q == P_IDLE) && cyc_end && !busy_req;
    assign inc_sum = {1'b0, MEM_WORD} + 19'h00001;
    ////////////////////////////////////////////////////////////////////////
    // Cycle phase counter
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ph_q <= 7'h00;
            pon_q <= 1'b1;
        end else begin
            ph_q <= cyc_end ? 7'h00 : ph_q + 7'h01;
            pon_q <= 1'b0;
        end
    end
    assign BUS.io_sync = (ph_q == `SYNC_AT);
    assign BUS.pwr_clear = pon_q || RESET_KEY ||
        (CMD_READY && CMD_VALID && CMD_OP == 3'(OP_CONTROL) &&
         CMD_INSTR == 18'h00000);
    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_q <= P_IDLE;
            instr_q <= `ZERO_WORD;
            acc_q <= `ZERO_WORD;
            op_q <= 3'h0;
            sub_q <= 2'h0;
            chan_wr_q <= 1'b0;
            addr_q <= 15'h0000;
            chreq_q <= 2'h0;
            apireq_q <= 4'h0;
        end else if (cyc_end) begin
            case (st_q)
                P_IDLE: begin
                    sub_q <= 2'h0;
                    if (|BUS.chan_req && (BUS.read_req || BUS.write_req)) begin
                        st_q <= P_CHAN;
                        chan_wr_q <= BUS.write_req;
                        chreq_q <= BUS.chan_req &
                            (~BUS.chan_req + 2'h1);
                        addr_q <= BUS.addr;
                    end else if (BUS.mem_inc_req) begin
                        st_q <= P_INC;
                        addr_q <= BUS.addr;
                    end else if (|BUS.api_req) begin
                        st_q <= P_API;
                        apireq_q <= BUS.api_req &
                            (~BUS.api_req + 4'h1);
                    end else if (CMD_VALID) begin
                        instr_q <= CMD_INSTR;
                        op_q <= CMD_OP;
                        acc_q <= CMD_ACC;
                        st_q <= (CMD_OP == 3'(OP_ADD_MEM)) ? P_ADD : P_IOT;
                    end
                end
                P_ADD: begin
                    sub_q <= sub_q + 2'h1;
                    if (sub_q == 2'h3) begin
                        st_q <= P_IDLE;
                    end
                end
                P_IOT, P_CHAN, P_INC, P_API: begin
                    st_q <= P_IDLE;
                end
                default: begin
                    st_q <= P_IDLE;
                end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Pulses and selection
    assign BUS.dev_sel = (st_q == P_IOT) ?
        instr_q[`SEL_MSB:`SEL_LSB] : 8'h00;
    assign BUS.flag_test_pulse = (st_q == P_IOT) && instr_q[0] &&
        ph_q == `P1_AT;
    assign BUS.input_transfer_pulse = ph_q == `P2_AT &&
        ((st_q == P_IOT && (instr_q[1] || op_q == 3'(OP_PROG_IN))) ||
         (st_q == P_CHAN && !chan_wr_q));
    assign BUS.output_transfer_pulse = ph_q == `P4_AT &&
        ((st_q == P_IOT && (instr_q[2] || op_q == 3'(OP_PROG_OUT))) ||
         (st_q == P_CHAN && chan_wr_q));
    assign BUS.read_status = (st_q == P_IOT) && op_q == 3'(OP_READ_FLAGS);
    assign BUS.data_p2d_oe = BUS.output_transfer_pulse;
    assign BUS.data_p2d = (st_q == P_CHAN) ? MEM_WORD : acc_q;
    assign BUS.io_overflow = (st_q == P_CHAN && WORD_COUNT == 18'h3ffff) ||
        (st_q == P_INC && inc_sum[18]);
    assign BUS.data_overflow = (st_q == P_ADD) && sub_q == 2'h2 &&
        ({1'b0, MEM_WORD} + {1'b0, acc_q} > 19'h3ffff);
    // Grants hold the request taken at cycle start, as the chain drops it
    assign BUS.api_grant = (st_q == P_API) ? apireq_q : 4'h0;
    assign BUS.chan_grant = (st_q == P_CHAN) ? chreq_q : 2'h0;
    assign BUS.enable_out = (st_q == P_IDLE);
    ////////////////////////////////////////////////////////////////////////
    // Results captured at the pulse phases or at cycle end, after bus settling
    assign f_valid = (st_q == P_CHAN) && BUS.input_transfer_pulse &&
        BUS.data_d2p_oe;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ACCUMULATOR <= `ZERO_WORD;
            PC_ADVANCE <= 15'h0000;
            TRAP <= 1'b0;
            TRAP_ADDR <= 15'h0000;
            NEXT_CUR_ADDR <= 15'h0000;
            INC_ADDR <= 15'h0000;
            VECTOR <= 15'h0000;
        end else begin
            TRAP <= 1'b0;
            if (st_q == P_IOT && ph_q == `P1_AT) begin
                PC_ADVANCE <= BUS.skip_req ? 15'h0002 : 15'h0001;
            end
            if ((BUS.read_status || BUS.input_transfer_pulse) &&
                st_q == P_IOT && BUS.data_d2p_oe) begin
                ACCUMULATOR <= BUS.data_d2p;
            end
            if (st_q == P_CHAN && cyc_end) begin
                NEXT_CUR_ADDR <= BUS.cur_addr_inhibit ? CUR_ADDR :
                    CUR_ADDR + 15'h0001;
            end
            if (st_q == P_INC && cyc_end) begin
                INC_ADDR <= addr_q;
            end
            if (st_q == P_API && ph_q == `P1_AT) begin
                VECTOR <= BUS.addr;
            end
            if (st_q == P_IDLE && cyc_end && BUS.prog_int_req &&
                !(|BUS.chan_req) && !BUS.mem_inc_req && !(|BUS.api_req)) begin
                TRAP <= 1'b1;
                TRAP_ADDR <= `PI_TRAP_ADDR;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Incoming word buffer
    iobus_fifo #(.WIDTH(18), .DEPTH(`FIFO_DEPTH)) in_fifo (
        .clk(CLK),
        .rst(RST),
        .in_valid(f_valid && st_q != P_IDLE),
        .in_ready(f_ready),
        .in_data(BUS.data_d2p),
        .out_valid(IN_VALID),
        .out_ready(IN_READY),
        .out_data(IN_VALID_WORD)
    );
    logic unused_ok;
    assign unused_ok = f_ready;
endmodule // iobus_processor

// >>> iobus_defines.svh
`ifndef IOBUS_DEFINES_SVH
`define IOBUS_DEFINES_SVH
// Bus widths
`define DATA_W 18
`define ADDR_W 15
`define SEL_W 8
`define API_LEVELS 4
// Selection field positions inside the 18-bit instruction latch
`define SEL_LSB 4
`define SEL_MSB 11
`define SUB_W 2
// Fixed trap and fetch locations of the program interrupt
`define PI_TRAP_ADDR 15'h0000
`define PI_FETCH_ADDR 15'h0001
// Processor cycle in clock cycles, and cycle index of sync pulse
`define IO_CYCLE_NS 1000
`define CLK_NS 10
`define IO_CYCLE_CLKS (`IO_CYCLE_NS / `CLK_NS)
`define SYNC_AT 7'h00
`define P1_AT 7'h14
`define P2_AT 7'h28
`define P4_AT 7'h3c
// Reset values
`define ZERO_WORD 18'h00000
`define FIFO_DEPTH 8
`endif

// >>> iobus_pkg.sv
package iobus_pkg;
`include "iobus_defines.svh"
typedef logic [`DATA_W-1:0] word_t;
typedef logic [`ADDR_W-1:0] addr_t;
typedef enum logic [2:0] {
    OP_CONTROL,
    OP_READ_FLAGS,
    OP_PROG_IN,
    OP_PROG_OUT,
    OP_ADD_MEM
} op_t;
typedef enum {
    P_IDLE,
    P_IOT,
    P_CHAN,
    P_INC,
    P_ADD,
    P_API
} pstate_t;
endpackage

// >>> iobus_if.sv
`timescale 1ns/10ps
interface iobus_if;
    import iobus_pkg::*;
    // Shared data lines, one driver set per end
    logic [17:0] data_p2d;
    logic data_p2d_oe;
    logic [17:0] data_d2p;
    logic data_d2p_oe;
    // Processor control pulses and levels
    logic pwr_clear;
    logic io_sync;
    logic flag_test_pulse;
    logic input_transfer_pulse;
    logic output_transfer_pulse;
    logic read_status;
    logic io_overflow;
    logic data_overflow;
    logic [7:0] dev_sel;
    // Device request levels
    logic prog_int_req;
    logic skip_req;
    logic read_req;
    logic write_req;
    logic mem_inc_req;
    logic cur_addr_inhibit;
    logic [14:0] addr;
    // Priority control lines
    logic [3:0] api_req;
    logic [3:0] api_grant;
    logic [1:0] chan_req;
    logic [1:0] chan_grant;
    logic enable_out;
    modport proc (
        output data_p2d, data_p2d_oe, pwr_clear, io_sync, flag_test_pulse,
        output input_transfer_pulse, output_transfer_pulse, read_status,
        output io_overflow, data_overflow, dev_sel, api_grant, chan_grant,
        output enable_out,
        input data_d2p, data_d2p_oe, prog_int_req, skip_req, read_req,
        input write_req, mem_inc_req, cur_addr_inhibit, addr, api_req,
        input chan_req
    );
    modport dev (
        input data_p2d, data_p2d_oe, pwr_clear, io_sync, flag_test_pulse,
        input input_transfer_pulse, output_transfer_pulse, read_status,
        input io_overflow, data_overflow, dev_sel, api_grant, chan_grant,
        input enable_out,
        output data_d2p, data_d2p_oe, prog_int_req, skip_req, read_req,
        output write_req, mem_inc_req, cur_addr_inhibit, addr, api_req,
        output chan_req
    );
endinterface

// >>> iobus_fifo.sv
`timescale 1ns/10ps
module iobus_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rp_q];
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // iobus_fifo

// >>> iobus_device.sv
`timescale 1ns/10ps
module iobus_device
    import iobus_pkg::*;
#(
    parameter logic [5:0] DEV_CODE = 6'h15,
    parameter logic [14:0] VECTOR = 15'h0024,
    parameter logic [14:0] WC_ADDR = 15'h0030,
    parameter int LEVEL = 0
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Bus
    iobus_if.dev BUS,
    // Enable chain
    input wire logic ENABLE_IN,
    output logic ENABLE_OUT,
    // User requests
    input wire logic INT_REQ,
    input wire logic CHAN_RD,
    input wire logic CHAN_WR,
    input wire logic INC_REQ,
    input wire logic [14:0] INC_ADDR,
    input wire logic INHIBIT,
    input wire logic [17:0] TX_DATA,
    // User results
    output logic [17:0] RX_DATA,
    output logic RX_STROBE,
    output logic FLAG,
    output logic READ_IN
);
    logic sel;
    logic flag_q;
    logic [17:0] rx_q;
    logic rx_stb_q;
    logic readin_q;
    logic serving_q;
    logic granted;
    logic to_me;
    assign sel = (BUS.dev_sel[7:2] == DEV_CODE);
    assign granted = BUS.api_grant[LEVEL] || (|BUS.chan_grant);
    // Addressed by selection code or by a channel grant
    assign to_me = sel || (|BUS.chan_grant);
    // Flag set by user event, cleared by clear pulse
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            flag_q <= 1'b0;
        end else if (INT_REQ) begin
            flag_q <= 1'b1;
        end else if (BUS.pwr_clear) begin
            flag_q <= 1'b0;
        end
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            readin_q <= 1'b0;
        end else begin
            readin_q <= BUS.pwr_clear && sel;
        end
    end
    // Capture on third pulse only
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rx_q <= `ZERO_WORD;
            rx_stb_q <= 1'b0;
        end else begin
            rx_stb_q <= BUS.output_transfer_pulse && to_me;
            if (BUS.output_transfer_pulse && to_me) begin
                rx_q <= BUS.data_p2d;
            end
        end
    end
    // Service holds chain until grant drops
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            serving_q <= 1'b0;
        end else begin
            serving_q <= granted && ENABLE_IN;
        end
    end
    assign ENABLE_OUT = ENABLE_IN && !flag_q && !serving_q;
    assign BUS.api_req = (ENABLE_IN && flag_q) ? 4'(1 << LEVEL) : 4'h0;
    assign BUS.chan_req = {1'b0, ENABLE_IN && (CHAN_RD || CHAN_WR)};
    assign BUS.prog_int_req = flag_q;
    assign BUS.skip_req = sel && BUS.flag_test_pulse && flag_q;
    assign BUS.read_req = CHAN_RD;
    assign BUS.write_req = CHAN_WR;
    assign BUS.mem_inc_req = INC_REQ;
    assign BUS.cur_addr_inhibit = INHIBIT;
    assign BUS.addr = BUS.api_grant[LEVEL] ? VECTOR :
                      (|BUS.chan_grant) ? WC_ADDR :
                      INC_REQ ? INC_ADDR : 15'h0000;
    assign BUS.data_d2p_oe = (to_me && BUS.input_transfer_pulse)
                             || BUS.read_status;
    assign BUS.data_d2p = BUS.read_status ? {17'h00000, flag_q} : TX_DATA;
    assign RX_DATA = rx_q;
    assign RX_STROBE = rx_stb_q;
    assign FLAG = flag_q;
    assign READ_IN = readin_q;
endmodule // iobus_device

// >>> iobus_assertions.sv
`timescale 1ns/10ps
module iobus_assertions #(
    parameter int CYCLE = 100
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Processor side
    input wire logic io_sync,
    input wire logic pwr_clear,
    input wire logic flag_test_pulse,
    input wire logic input_transfer_pulse,
    input wire logic output_transfer_pulse,
    input wire logic io_overflow,
    input wire logic data_overflow,
    input wire logic [7:0] dev_sel,
    input wire logic [3:0] api_grant,
    input wire logic [1:0] chan_grant,
    // Device side
    input wire logic data_d2p_oe,
    input wire logic [1:0] chan_req
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    logic [7:0] ph_q;
    logic seen_q;
    ////////////////////////////////////////////////////////////////////////
    // Clocks since the last sync pulse
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ph_q <= 8'h00;
        end else begin
            ph_q <= io_sync ? 8'h01 : ph_q + 8'h01;
        end
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            seen_q <= 1'b0;
        end else begin
            seen_q <= seen_q | io_sync;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    chk_sync_period: assert property (
        io_sync && seen_q |-> ph_q == 8'(CYCLE))
        else $error("sync spacing wrong");
    chk_sync_one_clock: assert property (
        io_sync |=> !io_sync [*8])
        else $error("sync pulse too long");
    chk_test_phase: assert property (
        flag_test_pulse |-> ph_q == 8'h14 && !data_d2p_oe)
        else $error("first pulse misplaced or data driven");
    chk_input_phase: assert property (
        input_transfer_pulse |-> ph_q == 8'h28)
        else $error("input pulse misplaced");
    chk_output_phase: assert property (
        output_transfer_pulse |-> ph_q == 8'h3c && !data_d2p_oe)
        else $error("output pulse misplaced or device drives");
    chk_sel_held: assert property (
        input_transfer_pulse |-> dev_sel == $past(dev_sel, 20))
        else $error("selection changed inside cycle");
    chk_grant_onehot: assert property (
        $onehot0(api_grant) && $onehot0(chan_grant))
        else $error("more than one grant");
    chk_grant_after_req: assert property (
        $rose(|chan_grant) |-> $past(|chan_req))
        else $error("channel grant without request");
    chk_clear_one_clock: assert property (
        pwr_clear |=> !pwr_clear)
        else $error("clear pulse too long");
    cover property (io_overflow);
    cover property (data_overflow);
    cover property (|api_grant);
    cover property (output_transfer_pulse);
endmodule // iobus_assertions

// >>> tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import iobus_pkg::*;
    localparam int CYC = 80;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rst_key = 1'b0, cmd_valid = 1'b0, in_ready = 1'b0, int_req = 1'b0;
    logic chan_rd = 1'b0, chan_wr = 1'b0, inc_req = 1'b0, inhibit = 1'b0;
    logic [2:0] cmd_op = 3'h0;
    word_t cmd_instr = '0, cmd_acc = '0, mem_word = '0, tx_data = '0;
    word_t word_count = '0;
    addr_t cur_addr = '0, inc_addr = '0;
    logic cmd_ready, in_valid, rx_strobe, read_in, trap, flag;
    word_t acc, in_word, rx_data;
    logic api_en = 1'b1;
    addr_t next_ca, inc_addr_o, vector, pc_adv, trap_addr;
    logic [6:0] seen = '0;
    logic [7:0] sel_at_out = '0;
    int miscompares = 0;
    int n_compared = 0;
    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    iobus_if bus ();
    iobus_processor #(.CYCLE(CYC)) iobus_processor_inst (.CLK(clk),
        .RST(rst), .BUS(bus), .RESET_KEY(rst_key), .CMD_VALID(cmd_valid),
        .CMD_READY(cmd_ready), .CMD_INSTR(cmd_instr), .CMD_OP(cmd_op),
        .CMD_ACC(cmd_acc), .MEM_WORD(mem_word), .WORD_COUNT(word_count),
        .CUR_ADDR(cur_addr), .ACCUMULATOR(acc), .PC_ADVANCE(pc_adv),
        .TRAP_ADDR(trap_addr), .TRAP(trap), .NEXT_CUR_ADDR(next_ca),
        .INC_ADDR(inc_addr_o), .IN_VALID_WORD(in_word),
        .IN_VALID(in_valid), .IN_READY(in_ready), .VECTOR(vector));
    iobus_device iobus_device_inst (.CLK(clk), .RST(rst), .BUS(bus),
        .ENABLE_IN(bus.enable_out && api_en), .ENABLE_OUT(),
        .INT_REQ(int_req),
        .CHAN_RD(chan_rd), .CHAN_WR(chan_wr), .INC_REQ(inc_req),
        .INC_ADDR(inc_addr), .INHIBIT(inhibit), .TX_DATA(tx_data),
        .RX_DATA(rx_data), .RX_STROBE(rx_strobe), .FLAG(flag),
        .READ_IN(read_in));
    iobus_assertions #(.CYCLE(CYC)) iobus_assertions_inst (.CLK(clk),
        .RST(rst), .io_sync(bus.io_sync), .pwr_clear(bus.pwr_clear),
        .flag_test_pulse(bus.flag_test_pulse),
        .input_transfer_pulse(bus.input_transfer_pulse),
        .output_transfer_pulse(bus.output_transfer_pulse),
        .io_overflow(bus.io_overflow), .data_overflow(bus.data_overflow),
        .dev_sel(bus.dev_sel), .api_grant(bus.api_grant),
        .chan_grant(bus.chan_grant), .data_d2p_oe(bus.data_d2p_oe),
        .chan_req(bus.chan_req));
    ////////////////////////////////////////////////////////////////////////
    // Sticky record of bus events
    always @(posedge clk) begin
        seen <= seen | {trap, read_in, |{bus.chan_grant, bus.api_grant},
            rx_strobe, bus.data_overflow, bus.io_overflow, bus.pwr_clear};
        if (bus.output_transfer_pulse) sel_at_out <= bus.dev_sel;
    end
    task automatic check(input string what, input word_t exp, word_t got);
        n_compared++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask
    task automatic complete_run;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic arm;
        @(negedge clk);
        seen = '0;
        @(posedge clk);
    endtask
    // Ready is looked at mid-cycle, where it has settled
    task automatic settle;
        for (int i = 0; i < 8 * CYC; i++) begin
            @(negedge clk);
            if (cmd_ready) break;
        end
        @(posedge clk);
    endtask
    task automatic cmd(input logic [2:0] op, input word_t ins, word_t a);
        logic took;
        took = 1'b0;
        cmd_op <= op;
        cmd_instr <= ins;
        cmd_acc <= a;
        cmd_valid <= 1'b1;
        for (int i = 0; i < 8 * CYC && !took; i++) begin
            @(negedge clk);
            took = cmd_ready;
            @(posedge clk);
        end
        cmd_valid <= 1'b0;
        @(posedge clk);
        settle();
    endtask
    task automatic serve;
        for (int i = 0; i < 4 * CYC && !seen[4]; i++) @(posedge clk);
        {int_req, chan_rd, chan_wr, inc_req} <= 4'h0;
        rst_key <= flag;
        @(posedge clk);
        rst_key <= 1'b0;
        @(posedge clk);
        settle();
    endtask
    task automatic take(input string what, input word_t exp);
        @(negedge clk);
        check("in valid", 18'h1, {17'h0, in_valid});
        check(what, exp, in_word);
        @(posedge clk);
        in_ready <= 1'b1;
        @(posedge clk);
        in_ready <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        complete_run();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        settle();
        check("power up clear", 18'h1, {17'h0, seen[0]});
        arm();
        cmd(3'h3, 18'h00540, 18'h2a5a5);
        check("out word", 18'h2a5a5, rx_data);
        check("out strobe", 18'h1, {17'h0, seen[3]});
        check("selection", 18'h00054, {10'h0, sel_at_out});
        tx_data <= 18'h1c3c3;
        cmd(3'h2, 18'h00540, 18'h00000);
        check("in word", 18'h1c3c3, acc);
        arm();
        cmd(3'h3, 18'h00a40, 18'h15555);
        check("foreign strobe", 18'h0, {17'h0, seen[3]});
        cmd(3'h1, 18'h00540, 18'h3ffff);
        check("status word", 18'h00000, acc);
        arm();
        cmd(3'h0, 18'h00000, 18'h00000);
        check("clear instr", 18'h1, {17'h0, seen[0]});
        arm();
        api_en <= 1'b0;
        int_req <= 1'b1;
        @(posedge clk);
        int_req <= 1'b0;
        cmd(3'h0, 18'h00541, 18'h00000);
        check("skip advance", 18'h00002, {3'h0, pc_adv});
        check("trap seen", 18'h1, {17'h0, seen[6]});
        check("trap addr", 18'h0, {3'h0, trap_addr});
        cmd(3'h1, 18'h00540, 18'h00000);
        check("flag status", 18'h00001, acc);
        arm();
        rst_key <= 1'b1;
        @(posedge clk);
        rst_key <= 1'b0;
        repeat (3) @(posedge clk);
        check("clear key", 18'h1, {17'h0, seen[0]});
        check("flag cleared", 18'h0, {17'h0, flag});
        check("no read-in", 18'h0, {17'h0, seen[5]});
        api_en <= 1'b1;
        arm();
        fork
            cmd(3'h2, 18'h00540, 18'h00000);
            begin
                while (bus.dev_sel != 8'h54) begin
                    @(posedge clk);
                end
                rst_key <= 1'b1;
                @(posedge clk);
                rst_key <= 1'b0;
            end
        join
        check("read-in", 18'h1, {17'h0, seen[5]});
        arm();
        int_req <= 1'b1;
        serve();
        check("api grant", 18'h1, {17'h0, seen[4]});
        check("vector", 18'h00024, {3'h0, vector});
        arm();
        mem_word <= 18'h0f0f0;
        word_count <= 18'h3ffff;
        cur_addr <= 15'h0100;
        chan_wr <= 1'b1;
        serve();
        check("chan write", 18'h0f0f0, rx_data);
        check("count overflow", 18'h1, {17'h0, seen[1]});
        check("addr step", 18'h00101, {3'h0, next_ca});
        arm();
        tx_data <= 18'h12345;
        word_count <= 18'h3fffe;
        inhibit <= 1'b1;
        chan_rd <= 1'b1;
        serve();
        inhibit <= 1'b0;
        check("no overflow", 18'h0, {17'h0, seen[1]});
        check("addr held", 18'h00100, {3'h0, next_ca});
        take("chan read", 18'h12345);
        for (int k = 0; k < 9; k++) begin
            arm();
            tx_data <= 18'h00100 + 18'(k);
            chan_rd <= 1'b1;
            serve();
        end
        for (int k = 0; k < 8; k++) begin
            take("fifo word", 18'h00100 + 18'(k));
        end
        @(negedge clk);
        check("fifo empty", 18'h0, {17'h0, in_valid});
        arm();
        mem_word <= 18'h3ffff;
        inc_addr <= 15'h0222;
        inc_req <= 1'b1;
        serve();
        check("inc addr", 18'h00222, {3'h0, inc_addr_o});
        check("inc overflow", 18'h1, {17'h0, seen[1]});
        arm();
        mem_word <= 18'h20000;
        cmd(3'h4, 18'h00540, 18'h20000);
        check("add overflow", 18'h1, {17'h0, seen[2]});
        complete_run();
    end
endmodule // tb_top
